// >>> rtl/mdeu_pkg.sv
package mdeu_pkg;

    localparam int        WORD_W        = 32;
    localparam int        HALF_W        = 16;
    localparam int        REG_COUNT     = 32;
    localparam int        ADDR_W        = 5;
    localparam int        SET_COUNT     = 2;
    localparam int        DIV_FULL_ITER = 32;
    localparam logic[5:0] DIV_SKIP_8    = 6'h17;
    localparam logic[5:0] DIV_SKIP_16   = 6'h0f;
    localparam logic[5:0] DIV_SKIP_24   = 6'h07;
    localparam logic[5:0] DIV_SKIP_NONE = 6'h00;
    localparam logic[31:0] WORD_RESET   = 32'h0000_0000;
    localparam logic[63:0] ACC_RESET    = 64'h0000_0000_0000_0000;

    typedef enum logic [2:0] {
        MDEU_MULT,
        MDEU_MULTU,
        MDEU_DIV,
        MDEU_DIVU
    } mdeu_mdu_op_type;

    typedef enum logic [3:0] {
        MDEU_ALU_AND,
        MDEU_ALU_OR,
        MDEU_ALU_XOR,
        MDEU_ALU_NOR,
        MDEU_ALU_ADD,
        MDEU_ALU_SUB,
        MDEU_ALU_SLL,
        MDEU_ALU_SRL,
        MDEU_ALU_SRA
    } mdeu_alu_op_type;

    typedef enum logic [1:0] {
        MDEU_DIV_IDLE,
        MDEU_DIV_RUN,
        MDEU_DIV_FIX
    } mdeu_div_state_type;

    typedef struct packed {
        logic            valid;
        mdeu_mdu_op_type op;
        logic [31:0]     firstSourceOperand;
        logic [31:0]     secondSourceOperand;
    } mdeu_mdu_req_type;

    typedef struct packed {
        logic            valid;
        mdeu_alu_op_type op;
        logic [31:0]     a;
        logic [31:0]     b;
    } mdeu_alu_req_type;

    typedef struct packed {
        logic        enable;
        logic [4:0]  addr;
        logic [31:0] data;
    } mdeu_rf_write_type;

endpackage

// >>> rtl/mdeu_top.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - multiply/divide pipeline runs on its own, never held by integer pipeline stalls
// - 32x16 multiplier array, high and low result registers, divide state machine
// - pass count chosen only from second operand value, detected by the unit itself
// - 16x16 and 32x16 use the array once, 32x32 uses it twice
// - short multiplies accepted every cycle, 32x32 at most every second cycle
// - issue stalls one cycle when any multiply/divide directly follows a 32x32 multiply
// - divide is iterative, resolving one quotient bit per clock
// - narrow dividends skip 23, 15 or 7 iterations for 8, 16, 24 bits
// - further multiply/divide issue during a divide stalls until the divide ends
// - thirty-two general registers of 32 bits each
// - a complete shadow set of thirty-two registers, selectable for exceptions
// - two read ports, one write port, writes bypassed to reads
// - logical, shift, add and subtract each finish in one clock
module mdeu_top #(
    parameter int DATA_W = mdeu_pkg::WORD_W
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire mdeu_pkg::mdeu_mdu_req_type mduReq,
    input  wire mdeu_pkg::mdeu_alu_req_type aluReq,
    input  wire mdeu_pkg::mdeu_rf_write_type rfWrite,
    input  wire logic                       shadowSel,
    input  wire logic [4:0]                 rdAddrA,
    input  wire logic [4:0]                 rdAddrB,
    output logic [31:0]                     rdDataA_r,
    output logic [31:0]                     rdDataB_r,
    output logic [31:0]                     aluResult_r,
    output logic                            aluValid_r,
    output logic [31:0]                     resultHigh_r,
    output logic [31:0]                     resultLow_r,
    output logic                            mduDone_r,
    output logic                            mduStall_r
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [49:0] arrayMul(input logic [32:0] a, input logic [16:0] b);
        arrayMul = 50'($signed(a) * $signed(b));
    endfunction

    function automatic logic [31:0] magnitude(input logic [31:0] v, input logic sgn);
        magnitude = (sgn && v[31]) ? 32'(-v) : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file with shadow set

    logic [31:0] regBank [mdeu_pkg::SET_COUNT * mdeu_pkg::REG_COUNT];

    always_ff @(posedge clock) begin
        if (rfWrite.enable) begin
            regBank[{shadowSel, rfWrite.addr}] <= rfWrite.data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdDataA_r <= mdeu_pkg::WORD_RESET;
            rdDataB_r <= mdeu_pkg::WORD_RESET;
        end else begin
            rdDataA_r <= (rfWrite.enable && rfWrite.addr == rdAddrA) ? rfWrite.data
                         : regBank[{shadowSel, rdAddrA}];
            rdDataB_r <= (rfWrite.enable && rfWrite.addr == rdAddrB) ? rfWrite.data
                         : regBank[{shadowSel, rdAddrB}];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // single-cycle alu

    logic [31:0] aluNxt;

    always_comb begin
        unique case (aluReq.op)
            mdeu_pkg::MDEU_ALU_AND: aluNxt = aluReq.a & aluReq.b;
            mdeu_pkg::MDEU_ALU_OR:  aluNxt = aluReq.a | aluReq.b;
            mdeu_pkg::MDEU_ALU_XOR: aluNxt = aluReq.a ^ aluReq.b;
            mdeu_pkg::MDEU_ALU_NOR: aluNxt = ~(aluReq.a | aluReq.b);
            mdeu_pkg::MDEU_ALU_ADD: aluNxt = 32'(aluReq.a + aluReq.b);
            mdeu_pkg::MDEU_ALU_SUB: aluNxt = 32'(aluReq.a - aluReq.b);
            mdeu_pkg::MDEU_ALU_SLL: aluNxt = aluReq.a << aluReq.b[4:0];
            mdeu_pkg::MDEU_ALU_SRL: aluNxt = aluReq.a >> aluReq.b[4:0];
            mdeu_pkg::MDEU_ALU_SRA: aluNxt = 32'($signed(aluReq.a) >>> aluReq.b[4:0]);
            default:                aluNxt = mdeu_pkg::WORD_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            aluResult_r <= mdeu_pkg::WORD_RESET;
            aluValid_r  <= 1'b0;
        end else begin
            aluResult_r <= aluNxt;
            aluValid_r  <= aluReq.valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // issue decode

    logic isMul;
    logic isDiv;
    logic sgnOp;
    logic rtShort;
    logic mulTake;
    logic divTake;

    always_comb begin
        isMul   = mduReq.valid && (mduReq.op == mdeu_pkg::MDEU_MULT ||
                                   mduReq.op == mdeu_pkg::MDEU_MULTU);
        isDiv   = mduReq.valid && (mduReq.op == mdeu_pkg::MDEU_DIV ||
                                   mduReq.op == mdeu_pkg::MDEU_DIVU);
        sgnOp   = mduReq.op == mdeu_pkg::MDEU_MULT || mduReq.op == mdeu_pkg::MDEU_DIV;
        rtShort = sgnOp ? (mduReq.secondSourceOperand[31:15] == {17{1'b0}} ||
                           mduReq.secondSourceOperand[31:15] == {17{1'b1}})
                        : (mduReq.secondSourceOperand[31:16] == 16'h0000);
        mulTake = isMul && !mduStall_r;
        divTake = isDiv && !mduStall_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // multiplier: one 33x17 signed array, one or two passes

    logic        pend2_r;
    logic [32:0] savedA_r;
    logic [15:0] savedHi_r;
    logic        savedSgn_r;
    logic [63:0] mulAcc_r;
    logic        mulDone_r;
    logic [32:0] arrA;
    logic [16:0] arrB;
    logic [49:0] arrOut;

    always_comb begin
        if (pend2_r) begin
            arrA = savedA_r;
            arrB = {savedSgn_r & savedHi_r[15], savedHi_r};
        end else begin
            arrA = {sgnOp & mduReq.firstSourceOperand[31], mduReq.firstSourceOperand};
            arrB = {(sgnOp & rtShort) & mduReq.secondSourceOperand[15],
                    mduReq.secondSourceOperand[15:0]};
        end
        arrOut = arrayMul(arrA, arrB);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pend2_r    <= 1'b0;
            savedA_r   <= 33'h0_0000_0000;
            savedHi_r  <= 16'h0000;
            savedSgn_r <= 1'b0;
            mulAcc_r   <= mdeu_pkg::ACC_RESET;
            mulDone_r  <= 1'b0;
        end else if (pend2_r) begin
            mulAcc_r  <= 64'(mulAcc_r + {{14{arrOut[49]}}, arrOut} * 64'h1_0000);
            pend2_r   <= 1'b0;
            mulDone_r <= 1'b1;
        end else if (mulTake) begin
            mulAcc_r   <= {{14{arrOut[49]}}, arrOut};
            pend2_r    <= !rtShort;
            mulDone_r  <= rtShort;
            savedA_r   <= arrA;
            savedHi_r  <= mduReq.secondSourceOperand[31:16];
            savedSgn_r <= sgnOp;
        end else begin
            mulDone_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider: restoring, one quotient bit per clock

    mdeu_pkg::mdeu_div_state_type divState_r;
    logic [5:0]  divCount_r;
    logic [32:0] divRem_r;
    logic [31:0] divQuo_r;
    logic [31:0] divisor_r;
    logic        negQuo_r;
    logic        negRem_r;
    logic [31:0] dvdMag;
    logic [5:0]  skip;
    logic [32:0] remShift;
    logic [32:0] trial;

    always_comb begin
        dvdMag = magnitude(mduReq.firstSourceOperand, sgnOp);
        if (sgnOp ? ($signed(mduReq.firstSourceOperand) >= -32'sd128 &&
                     $signed(mduReq.firstSourceOperand) <= 32'sd127)
                  : mduReq.firstSourceOperand[31:8] == 24'h00_0000) begin
            skip = mdeu_pkg::DIV_SKIP_8;
        end else if (sgnOp ? ($signed(mduReq.firstSourceOperand) >= -32'sd32768 &&
                              $signed(mduReq.firstSourceOperand) <= 32'sd32767)
                           : mduReq.firstSourceOperand[31:16] == 16'h0000) begin
            skip = mdeu_pkg::DIV_SKIP_16;
        end else if (sgnOp ? ($signed(mduReq.firstSourceOperand) >= -32'sd8388608 &&
                              $signed(mduReq.firstSourceOperand) <= 32'sd8388607)
                           : mduReq.firstSourceOperand[31:24] == 8'h00) begin
            skip = mdeu_pkg::DIV_SKIP_24;
        end else begin
            skip = mdeu_pkg::DIV_SKIP_NONE;
        end
        remShift = {divRem_r[31:0], divQuo_r[31]};
        trial    = 33'(remShift - {1'b0, divisor_r});
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            divState_r <= mdeu_pkg::MDEU_DIV_IDLE;
            divCount_r <= 6'h00;
            divRem_r   <= 33'h0_0000_0000;
            divQuo_r   <= mdeu_pkg::WORD_RESET;
            divisor_r  <= mdeu_pkg::WORD_RESET;
            negQuo_r   <= 1'b0;
            negRem_r   <= 1'b0;
        end else begin
            unique case (divState_r)
                mdeu_pkg::MDEU_DIV_IDLE: begin
                    if (divTake) begin
                        divState_r <= mdeu_pkg::MDEU_DIV_RUN;
                        divCount_r <= 6'(mdeu_pkg::DIV_FULL_ITER - 32'(skip));
                        divQuo_r   <= dvdMag << skip;
                        divRem_r   <= 33'h0_0000_0000;
                        divisor_r  <= magnitude(mduReq.secondSourceOperand, sgnOp);
                        negQuo_r   <= sgnOp && (mduReq.firstSourceOperand[31] ^
                                                mduReq.secondSourceOperand[31]);
                        negRem_r   <= sgnOp && mduReq.firstSourceOperand[31];
                    end
                end
                mdeu_pkg::MDEU_DIV_RUN: begin
                    if (trial[32]) begin
                        divRem_r <= remShift;
                        divQuo_r <= {divQuo_r[30:0], 1'b0};
                    end else begin
                        divRem_r <= trial;
                        divQuo_r <= {divQuo_r[30:0], 1'b1};
                    end
                    divCount_r <= 6'(divCount_r - 6'h01);
                    if (divCount_r == 6'h01) begin
                        divState_r <= mdeu_pkg::MDEU_DIV_FIX;
                    end
                end
                mdeu_pkg::MDEU_DIV_FIX: begin
                    divState_r <= mdeu_pkg::MDEU_DIV_IDLE;
                end
                default: divState_r <= mdeu_pkg::MDEU_DIV_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result registers and stall

    logic divFinish;
    logic stallNxt;

    always_comb begin
        divFinish = divState_r == mdeu_pkg::MDEU_DIV_FIX;
        stallNxt  = (divState_r == mdeu_pkg::MDEU_DIV_IDLE) ? (divTake || (mulTake && !rtShort))
                  : (divState_r == mdeu_pkg::MDEU_DIV_RUN);
    end

    // advances every cycle; no integer pipeline stall enters here
    always_ff @(posedge clock) begin
        if (rst) begin
            mduStall_r <= 1'b0;
        end else begin
            mduStall_r <= stallNxt;
        end
    end

    // one-cycle pulse in the cycle that first shows new results
    always_ff @(posedge clock) begin
        if (rst) begin
            mduDone_r <= 1'b0;
        end else begin
            mduDone_r <= mulDone_r || divFinish;
        end
    end

    // quotient low and remainder high, or product high and low halves
    always_ff @(posedge clock) begin
        if (rst) begin
            resultHigh_r <= mdeu_pkg::WORD_RESET;
            resultLow_r  <= mdeu_pkg::WORD_RESET;
        end else begin
            if (divFinish) begin
                resultLow_r  <= negQuo_r ? 32'(-divQuo_r) : divQuo_r;
                resultHigh_r <= negRem_r ? 32'(-divRem_r[31:0]) : divRem_r[31:0];
            end else if (mulDone_r) begin
                resultHigh_r <= mulAcc_r[63:32];
                resultLow_r  <= mulAcc_r[31:0];
            end
        end
    end

endmodule

`default_nettype wire

// >>> sim/mdeu_chk.sv
`timescale 1ns/1ns
`default_nettype none
module mdeu_chk (
    input wire logic                         clock,
    input wire logic                         rst,
    input wire mdeu_pkg::mdeu_mdu_req_type   mduReq,
    input wire mdeu_pkg::mdeu_alu_req_type   aluReq,
    input wire mdeu_pkg::mdeu_rf_write_type  rfWrite,
    input wire logic                         shadowSel,
    input wire logic [4:0]                   rdAddrA,
    input wire logic [4:0]                   rdAddrB,
    input wire logic [31:0]                  rdDataA_r,
    input wire logic [31:0]                  rdDataB_r,
    input wire logic [31:0]                  aluResult_r,
    input wire logic                         aluValid_r,
    input wire logic [31:0]                  resultHigh_r,
    input wire logic [31:0]                  resultLow_r,
    input wire logic                         mduDone_r,
    input wire logic                         mduStall_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    function automatic logic fits(input logic sg, input logic [31:0] v, input int w);
        logic [31:0] t;
        t = sg ? 32'($signed(v) >>> (w - 1)) : v >> w;
        return sg ? (t == 32'h0 || t == 32'hffffffff) : t == 32'h0;
    endfunction
    logic take, isMul, shortM, div8, div32;
    always_comb begin
        take   = mduReq.valid && !mduStall_r;
        isMul  = mduReq.op inside {mdeu_pkg::MDEU_MULT, mdeu_pkg::MDEU_MULTU};
        shortM = fits(mduReq.op == mdeu_pkg::MDEU_MULT, mduReq.secondSourceOperand, 16);
        div8   = fits(mduReq.op == mdeu_pkg::MDEU_DIV, mduReq.firstSourceOperand, 8);
        div32  = !fits(mduReq.op == mdeu_pkg::MDEU_DIV, mduReq.firstSourceOperand, 24);
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_short_done: assert property (take && isMul && shortM |-> ##2 mduDone_r)
        else $error("short multiply result late");
    a_short_free: assert property (take && isMul && shortM |=> !mduStall_r)
        else $error("short multiply stalled issue");
    a_long_done: assert property (take && isMul && !shortM |-> ##3 mduDone_r)
        else $error("full multiply result late");
    a_long_stall: assert property (take && isMul && !shortM
        |=> mduStall_r ##1 !mduStall_r)
        else $error("full multiply stall not one cycle");
    a_div_busy: assert property (take && !isMul |=> mduStall_r [*8])
        else $error("divide did not hold issue");
    a_div_full: assert property (take && !isMul && div32 |-> ##34 mduDone_r)
        else $error("full divide not done in time");
    a_div_byte: assert property (take && !isMul && div8 |-> ##11 mduDone_r)
        else $error("byte divide not done in time");
    a_alu_add: assert property (aluReq.valid && aluReq.op == mdeu_pkg::MDEU_ALU_ADD
        |=> aluValid_r && aluResult_r == $past(aluReq.a) + $past(aluReq.b))
        else $error("add result wrong");
    a_rf_bypass: assert property (rfWrite.enable && rfWrite.addr == rdAddrA
        |=> rdDataA_r == $past(rfWrite.data))
        else $error("write not bypassed to read");
endmodule
bind mdeu_top mdeu_chk chk (.clock, .rst, .mduReq, .aluReq, .rfWrite, .shadowSel, .rdAddrA,
    .rdAddrB, .rdDataA_r, .rdDataB_r, .aluResult_r, .aluValid_r, .resultHigh_r, .resultLow_r,
    .mduDone_r, .mduStall_r);
`default_nettype wire

// >>> sim/mdeu_issuer.sv
`timescale 1ns/1ns
`default_nettype none
module mdeu_issuer (
    input wire logic                        clock,
    input wire logic                        mduStall_r,
    output var mdeu_pkg::mdeu_mdu_req_type  mduReq
);
    initial mduReq = '0;
    // called at a falling edge; holds the request until an edge takes it
    task automatic issue(input mdeu_pkg::mdeu_mdu_req_type r, output int waits);
        waits = 0;
        mduReq <= r;
        while (mduStall_r !== 1'b0 && waits < 100) begin
            @(negedge clock);
            waits++;
        end
        @(negedge clock);
    endtask
    task automatic idle();
        mduReq.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sim/mdeu_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mdeu_tb_top;
    logic                        clock, rst, shadowSel, aluValid_r, mduDone_r, mduStall_r;
    logic [4:0]                  rdAddrA, rdAddrB;
    logic [31:0]                 rdDataA_r, rdDataB_r, aluResult_r, resultHigh_r, resultLow_r;
    mdeu_pkg::mdeu_mdu_req_type  mduReq;
    mdeu_pkg::mdeu_alu_req_type  aluReq;
    mdeu_pkg::mdeu_rf_write_type rfWrite;
    int                          bad_count = 0;
    int                          n_checks = 0;
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    mdeu_top dut (.clock, .rst, .mduReq, .aluReq, .rfWrite, .shadowSel, .rdAddrA, .rdAddrB,
        .rdDataA_r, .rdDataB_r, .aluResult_r, .aluValid_r, .resultHigh_r, .resultLow_r,
        .mduDone_r, .mduStall_r);
    mdeu_issuer drv (.clock, .mduStall_r, .mduReq);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_done(output int n);
        n = 1;
        while (mduDone_r !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        if (n == 60) begin
            bad_count++;
            complete_run();
        end
    endtask
    function automatic logic [63:0] mexp(mdeu_pkg::mdeu_mdu_op_type op, logic [31:0] a, b);
        case (op)
            mdeu_pkg::MDEU_MULT:  return $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
            mdeu_pkg::MDEU_MULTU: return {32'h0, a} * {32'h0, b};
            mdeu_pkg::MDEU_DIV:   return {32'($signed(a) % $signed(b)),
                                          32'($signed(a) / $signed(b))};
            default:              return {a % b, a / b};
        endcase
    endfunction
    function automatic logic [31:0] aexp(int op, logic [31:0] a, b);
        case (op)
            0: return a & b;
            1: return a | b;
            2: return a ^ b;
            3: return ~(a | b);
            4: return a + b;
            5: return a - b;
            6: return a << b[4:0];
            7: return a >> b[4:0];
            default: return 32'($signed(a) >>> b[4:0]);
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic send(input mdeu_pkg::mdeu_mdu_req_type r, output int w);
        drv.issue(r, w);
        if (w >= 100) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic run_mdu(mdeu_pkg::mdeu_mdu_op_type op, logic [31:0] a, b, int lat);
        int w, n;
        send({1'b1, op, a, b}, w);
        drv.idle();
        check(w, 0);
        wait_done(n);
        check(n, lat);
        check({resultHigh_r, resultLow_r}, mexp(op, a, b));
    endtask
    task automatic run_pair(mdeu_pkg::mdeu_mdu_op_type o1, o2, logic [31:0] b1, b2,
                            int wExp, logic dExp);
        int w, n;
        send({1'b1, o1, 32'hffff_fff0, b1}, w);
        send({1'b1, o2, 32'h0000_0345, b2}, w);
        drv.idle();
        check(w, wExp);
        check(mduDone_r, dExp);
        check({resultHigh_r, resultLow_r}, mexp(o1, 32'hffff_fff0, b1));
        @(negedge clock);
        wait_done(n);
        check({resultHigh_r, resultLow_r}, mexp(o2, 32'h0000_0345, b2));
    endtask
    task automatic t_alu();
        for (int i = 0; i < 10; i++) begin
            if (i > 0) begin
                check(aluValid_r, 1'b1);
                check(aluResult_r, aexp(i - 1, 32'hf0f0_1234, 32'(i)));
            end
            aluReq <= {i < 9, mdeu_pkg::mdeu_alu_op_type'(i), 32'hf0f0_1234, 32'(i + 1)};
            @(negedge clock);
        end
    endtask
    task automatic t_rf();
        for (int s = 0; s < 2; s++) for (int i = 0; i < 32; i++) begin
            shadowSel <= s[0];
            rfWrite <= {1'b1, 5'(i), 32'(32'h1000_0000 * (s + 1) + i)};
            rdAddrA <= 5'(i);
            @(negedge clock);
            check(rdDataA_r, rfWrite.data);
        end
        for (int s = 0; s < 2; s++) for (int i = 0; i < 32; i++) begin
            shadowSel <= s[0];
            rfWrite <= '0;
            rdAddrA <= 5'(i);
            rdAddrB <= 5'(31 - i);
            @(negedge clock);
            check(rdDataA_r, 32'(32'h1000_0000 * (s + 1) + i));
            check(rdDataB_r, 32'(32'h1000_0000 * (s + 1) + 31 - i));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        aluReq = '0;
        rfWrite = '0;
        shadowSel = 1'b0;
        rdAddrA = 5'h00;
        rdAddrB = 5'h00;
        repeat (3) @(negedge clock);
        rst <= 1'b0;
        @(negedge clock);
        run_mdu(mdeu_pkg::MDEU_MULT, 32'h0000_1234, 32'hffff_8000, 2);
        run_mdu(mdeu_pkg::MDEU_MULTU, 32'hffff_ffff, 32'h0000_ffff, 2);
        run_mdu(mdeu_pkg::MDEU_MULT, 32'h8000_0001, 32'h0000_8000, 3);
        run_mdu(mdeu_pkg::MDEU_MULTU, 32'h1234_5678, 32'h0001_0000, 3);
        run_mdu(mdeu_pkg::MDEU_DIV, 32'hffff_ff85, 32'h0000_0007, 32 - 23 + 2);
        run_mdu(mdeu_pkg::MDEU_DIV, 32'h0000_0080, 32'h0000_0003, 32 - 15 + 2);
        run_mdu(mdeu_pkg::MDEU_DIVU, 32'h0000_0080, 32'h0000_0003, 32 - 23 + 2);
        run_mdu(mdeu_pkg::MDEU_DIVU, 32'h00ff_ffff, 32'h0000_0010, 32 - 7 + 2);
        run_mdu(mdeu_pkg::MDEU_DIVU, 32'hffff_fff0, 32'h0000_0010, 32 + 2);
        run_mdu(mdeu_pkg::MDEU_DIV, 32'h8000_0001, 32'h0000_0002, 32 + 2);
        run_pair(mdeu_pkg::MDEU_MULT, mdeu_pkg::MDEU_MULT, 32'h0000_7fff, 32'h0000_0011,
                 0, 1'b1);
        run_pair(mdeu_pkg::MDEU_MULTU, mdeu_pkg::MDEU_MULTU, 32'h8000_0000, 32'h0002_0003,
                 1, 1'b1);
        run_pair(mdeu_pkg::MDEU_DIVU, mdeu_pkg::MDEU_MULT, 32'h0000_0003, 32'h0000_0021,
                 33, 1'b0);
        t_alu();
        t_rf();
        rst <= 1'b1;
        @(negedge clock);
        check({mduDone_r, mduStall_r, aluValid_r, resultLow_r}, 64'h0);
        complete_run();
    end
endmodule
`default_nettype wire
